// File: core/tem_top.v
`include "tem_defs.vh"

// Summary of operation
// - Six SCI select bits, bits 5..0 cat/hot/aux3..aux0; set enables SCI.
// - SCI messages go out only while global thermal SCI enable is set.
// - Six interrupt select bits; a set bit makes its trip send interrupts.
// - Enable bit 7 is write-once set, locks lockable bits, reset clears.
// - External trip inputs only reach indicator bits 3 and 2 while the external enable is 0.
// - Low level on an external trip input means an asserted trip.
// - External trips raise the same messages as internal sensor trips.
// - Internal and external throttling requests are combined by OR.
// - Bit 6 picks DRAM throttling at 0, controller throttling at 1.
// - Second input acts as hot trip at bit5=0, aux0 trip at bit5=1.
// - First input acts as catastrophic at bit4=0, hot trip at bit4=1.
// - Read-only trip indicators: bit 3 first input, bit 2 second.
// - Bit 0 routes external trips to sensor set one or set two.
// - Writes to bits 6, 5, 4 and 0 are ignored once locked.
module tem_top
(
    input  wire                    mclk_in,
    input  wire                    rst_in,
    input  wire [15:0]             reg_addr_in,
    input  wire                    reg_wr_in,
    input  wire [7:0]              reg_wdata_in,
    input  wire                    reg_rd_in,
    output reg  [7:0]              reg_rdata_out,
    output reg                     reg_rvalid_out,
    input  wire [`TEM_EV_W-1:0]    int_trip_set1_in,
    input  wire [`TEM_EV_W-1:0]    int_trip_set2_in,
    input  wire                    int_throttle_enable_in,
    input  wire                    first_external_trip_n_in,
    input  wire                    second_external_trip_n_in,
    input  wire                    sci_thermal_enable_in,
    output reg                     sci_msg_out,
    output reg  [`TEM_EV_W-1:0]    sci_event_out,
    output reg                     intr_msg_out,
    output reg  [`TEM_EV_W-1:0]    intr_event_out,
    output reg  [`TEM_EV_W-1:0]    trip_set1_out,
    output reg  [`TEM_EV_W-1:0]    trip_set2_out,
    output reg                     throttle_req_out,
    output reg                     dram_throttle_out,
    output reg                     ctrl_throttle_out
);

    reg  [`TEM_EV_W-1:0] thermal_sci_select;
    reg  [`TEM_EV_W-1:0] thermal_interrupt_select;
    reg                  external_sensor_enable;
    reg                  throttling_type_select;
    reg                  second_input_action_select;
    reg                  first_input_action_select;
    reg                  route_select;
    reg                  first_pin_n;
    reg                  second_pin_n;

    wire                 first_trip;
    wire                 second_trip;
    wire                 ext_any;
    wire [`TEM_EV_W-1:0] ext_ev;
    wire [`TEM_EV_W-1:0] next_set1;
    wire [`TEM_EV_W-1:0] next_set2;
    wire [`TEM_EV_W-1:0] ev_rise;
    wire [`TEM_EV_W-1:0] next_sci_ev;
    wire [`TEM_EV_W-1:0] next_intr_ev;
    wire [7:0]           ext_ctrl_read;
    wire                 wr_sci;
    wire                 wr_intr;
    wire                 wr_ext;
    wire                 next_dram;
    wire                 next_ctrl;

    function hit;
        input [15:0] addr;
        input [15:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    assign wr_sci  = reg_wr_in & hit(reg_addr_in, `TEM_SCI_SELECT_OFF);
    assign wr_intr = reg_wr_in & hit(reg_addr_in, `TEM_INTR_SELECT_OFF);
    assign wr_ext  = reg_wr_in & hit(reg_addr_in, `TEM_EXT_CTRL_OFF);

    // Pins are registered once so every consumer sees the same sample
    assign first_trip  = external_sensor_enable & ~first_pin_n;
    assign second_trip = external_sensor_enable & ~second_pin_n;
    assign ext_any     = first_trip | second_trip;

    // Both inputs may land on hot; they simply merge
    assign ext_ev[`TEM_EV_CAT]  = first_trip & ~first_input_action_select;
    assign ext_ev[`TEM_EV_HOT]  = (first_trip & first_input_action_select)
                                | (second_trip & ~second_input_action_select);
    assign ext_ev[`TEM_EV_AUX3] = 1'b0;
    assign ext_ev[`TEM_EV_AUX2] = 1'b0;
    assign ext_ev[`TEM_EV_AUX1] = 1'b0;
    assign ext_ev[`TEM_EV_AUX0] = second_trip & second_input_action_select;

    assign next_set1 = int_trip_set1_in
                     | (route_select ? {`TEM_EV_W{1'b0}} : ext_ev);
    assign next_set2 = int_trip_set2_in
                     | (route_select ? ext_ev : {`TEM_EV_W{1'b0}});

    assign next_sci_ev  = ev_rise & thermal_sci_select
                        & {`TEM_EV_W{sci_thermal_enable_in}};
    assign next_intr_ev = ev_rise & thermal_interrupt_select;

    assign next_dram = ext_any & ~throttling_type_select;
    assign next_ctrl = ext_any & throttling_type_select;

    assign ext_ctrl_read = {external_sensor_enable,
                            throttling_type_select,
                            second_input_action_select,
                            first_input_action_select,
                            ~first_pin_n,
                            ~second_pin_n,
                            1'b0,
                            route_select};

    // Edges are taken on the merged view of both sensor sets
    tem_edge u_edge
    (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .level_in (trip_set1_out | trip_set2_out),
        .rise_out (ev_rise)
    );

    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            thermal_sci_select         <= `TEM_SCI_SELECT_RST;
            thermal_interrupt_select   <= `TEM_INTR_SELECT_RST;
            external_sensor_enable     <= `TEM_EXT_CTRL_RST;
            throttling_type_select     <= `TEM_EXT_CTRL_RST;
            second_input_action_select <= `TEM_EXT_CTRL_RST;
            first_input_action_select  <= `TEM_EXT_CTRL_RST;
            route_select               <= `TEM_EXT_CTRL_RST;
        end
        else
        begin
            if (wr_sci)
            begin
                thermal_sci_select <= reg_wdata_in[`TEM_EV_W-1:0];
            end
            if (wr_intr)
            begin
                thermal_interrupt_select <= reg_wdata_in[`TEM_EV_W-1:0];
            end
            if (wr_ext)
            begin
                // The write that sets the enable may still load the fields
                if (reg_wdata_in[`TEM_EXT_ENABLE_BIT])
                begin
                    external_sensor_enable <= 1'b1;
                end
                if (!external_sensor_enable)
                begin
                    throttling_type_select     <=
                        reg_wdata_in[`TEM_EXT_TTS_BIT];
                    second_input_action_select <=
                        reg_wdata_in[`TEM_EXT_AS1_BIT];
                    first_input_action_select  <=
                        reg_wdata_in[`TEM_EXT_AS0_BIT];
                    route_select               <=
                        reg_wdata_in[`TEM_EXT_ROUTE_BIT];
                end
            end
        end
    end

    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            first_pin_n       <= 1'b1;
            second_pin_n      <= 1'b1;
            trip_set1_out     <= {`TEM_EV_W{1'b0}};
            trip_set2_out     <= {`TEM_EV_W{1'b0}};
            sci_msg_out       <= 1'b0;
            sci_event_out     <= {`TEM_EV_W{1'b0}};
            intr_msg_out      <= 1'b0;
            intr_event_out    <= {`TEM_EV_W{1'b0}};
            throttle_req_out  <= 1'b0;
            dram_throttle_out <= 1'b0;
            ctrl_throttle_out <= 1'b0;
        end
        else
        begin
            first_pin_n       <= first_external_trip_n_in;
            second_pin_n      <= second_external_trip_n_in;
            trip_set1_out     <= next_set1;
            trip_set2_out     <= next_set2;
            sci_msg_out       <= |next_sci_ev;
            sci_event_out     <= next_sci_ev;
            intr_msg_out      <= |next_intr_ev;
            intr_event_out    <= next_intr_ev;
            throttle_req_out  <= ext_any
                               | (int_throttle_enable_in
                                  & |(int_trip_set1_in
                                      | int_trip_set2_in));
            dram_throttle_out <= next_dram;
            ctrl_throttle_out <= next_ctrl;
        end
    end

    // Register reads answer one cycle later; unmapped offsets read zero
    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (!reg_rd_in)
            begin
                reg_rdata_out <= 8'h00;
            end
            else if (hit(reg_addr_in, `TEM_SCI_SELECT_OFF))
            begin
                reg_rdata_out <= {2'h0, thermal_sci_select};
            end
            else if (hit(reg_addr_in, `TEM_INTR_SELECT_OFF))
            begin
                reg_rdata_out <= {2'h0, thermal_interrupt_select};
            end
            else if (hit(reg_addr_in, `TEM_EXT_CTRL_OFF))
            begin
                reg_rdata_out <= ext_ctrl_read;
            end
            else
            begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

endmodule // tem_top

// File: common/tem_defs.vh
`ifndef TEM_DEFS_VH
`define TEM_DEFS_VH

// Register byte offsets inside the memory-mapped register window
`define TEM_SCI_SELECT_OFF      16'h10E6
`define TEM_INTR_SELECT_OFF     16'h10E7
`define TEM_EXT_CTRL_OFF        16'h10EF

// Reset values
`define TEM_SCI_SELECT_RST      6'h00
`define TEM_INTR_SELECT_RST     6'h00
`define TEM_EXT_CTRL_RST        1'h0

// Event vector positions, shared by both select registers
`define TEM_EV_CAT              5
`define TEM_EV_HOT              4
`define TEM_EV_AUX3             3
`define TEM_EV_AUX2             2
`define TEM_EV_AUX1             1
`define TEM_EV_AUX0             0
`define TEM_EV_W                6

// External sensor control and status fields
`define TEM_EXT_ENABLE_BIT      7
`define TEM_EXT_TTS_BIT         6
`define TEM_EXT_AS1_BIT         5
`define TEM_EXT_AS0_BIT         4
`define TEM_EXT_TI0_BIT         3
`define TEM_EXT_TI1_BIT         2
`define TEM_EXT_ROUTE_BIT       0

`endif

// File: core/tem_edge.v
`include "tem_defs.vh"

// Rising edge finder for the event vector; output is registered
module tem_edge
(
    input  wire                    mclk_in,
    input  wire                    rst_in,
    input  wire [`TEM_EV_W-1:0]    level_in,
    output reg  [`TEM_EV_W-1:0]    rise_out
);

    reg [`TEM_EV_W-1:0] last;

    always @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            last     <= {`TEM_EV_W{1'b0}};
            rise_out <= {`TEM_EV_W{1'b0}};
        end
        else
        begin
            last     <= level_in;
            rise_out <= level_in & ~last;
        end
    end

endmodule // tem_edge

// File: bench/tem_top_assertions.sv
`include "tem_defs.vh"
module tem_chk
(
    input logic       mclk_in,
    input logic       rst_in,
    input logic       reg_rd_in,
    input logic [7:0] reg_rdata_out,
    input logic       reg_rvalid_out,
    input logic [5:0] int_trip_set1_in,
    input logic       first_external_trip_n_in,
    input logic       second_external_trip_n_in,
    input logic       sci_thermal_enable_in,
    input logic       sci_msg_out,
    input logic [5:0] sci_event_out,
    input logic       intr_msg_out,
    input logic [5:0] intr_event_out,
    input logic [5:0] trip_set1_out,
    input logic [5:0] trip_set2_out,
    input logic       throttle_req_out,
    input logic       dram_throttle_out,
    input logic       ctrl_throttle_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] m;
    assign m = trip_set1_out | trip_set2_out;
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_answer;
        ##1 reg_rvalid_out;
    endsequence
    sequence s_quiet;
        ##1 !reg_rvalid_out && reg_rdata_out == 8'h00;
    endsequence
    chk_read_answer:
    assert property (reg_rd_in |-> s_answer) else $error("no read answer");
    chk_idle_quiet:
    assert property (!reg_rd_in |-> s_quiet) else $error("stray answer");
    chk_set_follow:
    assert property (1'b1 |=> (trip_set1_out & $past(int_trip_set1_in))
        == $past(int_trip_set1_in)) else $error("trip lost");
    chk_sci_rise:
    assert property (sci_msg_out |-> sci_event_out != 6'h00
        && ($past(m, 2) & sci_event_out) == sci_event_out
        && ($past(m, 3) & sci_event_out) == 6'h00) else $error("sci no rise");
    chk_intr_rise:
    assert property (intr_msg_out |-> intr_event_out != 6'h00
        && ($past(m, 2) & intr_event_out) == intr_event_out
        && ($past(m, 3) & intr_event_out) == 6'h00) else $error("intr no rise");
    chk_sci_gate:
    assert property (sci_msg_out |-> $past(sci_thermal_enable_in))
        else $error("sci while off");
    chk_throttle_kind:
    assert property (!(dram_throttle_out && ctrl_throttle_out))
        else $error("two throttle kinds");
    chk_throttle_req:
    assert property (dram_throttle_out || ctrl_throttle_out
        |-> throttle_req_out) else $error("throttle not requested");
    chk_pins_quiet:
    assert property ($past(first_external_trip_n_in, 2)
        && $past(second_external_trip_n_in, 2)
        |-> !dram_throttle_out && !ctrl_throttle_out) else $error("no trip");
endmodule // tem_chk

bind tem_top tem_chk u_chk (.*);

// File: bench/tem_hub_model.sv
module tem_hub_model
(
    input  wire logic mclk_in,
    input  wire logic sci_msg_in,
    input  wire logic intr_msg_in,
    output int        sci_cnt_out,
    output int        intr_cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Tally only; payloads are judged by the bench
    initial sci_cnt_out = 0;
    initial intr_cnt_out = 0;
    always @(posedge mclk_in)
    begin
        sci_cnt_out <= sci_cnt_out + int'(sci_msg_in);
        intr_cnt_out <= intr_cnt_out + int'(intr_msg_in);
    end
endmodule // tem_hub_model

// File: bench/tem_top_tb_top.sv
`include "tem_defs.vh"
module tem_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic        sci_thermal_enable_in = 0, int_throttle_enable_in = 0;
    logic        first_external_trip_n_in = 1, second_external_trip_n_in = 1;
    logic        reg_rvalid_out, sci_msg_out, intr_msg_out, throttle_req_out;
    logic        dram_throttle_out, ctrl_throttle_out;
    logic [15:0] reg_addr_in = 0;
    logic [7:0]  reg_wdata_in = 0, reg_rdata_out, rd_q[$];
    logic [7:0]  cfg[2] = '{8'hB1, 8'hC0};
    logic [5:0]  int_trip_set1_in = 0, int_trip_set2_in = 0, ev, sci_q[$];
    logic [5:0]  sci_event_out, intr_event_out, trip_set1_out, trip_set2_out;
    logic [5:0]  intr_q[$], ev0[2] = '{6'h10, 6'h20}, ev1[2] = '{6'h01, 6'h10};
    logic [31:0] r, exp_v, seed = 32'h700675B6;
    int          error_cnt = 0, total_checks = 0, sci_n = 0, intr_n = 0;
    int          sci_cnt, intr_cnt;
    always #20 mclk_in = ~mclk_in;
    tem_top DUT (.*);
    tem_hub_model hub (.mclk_in, .sci_msg_in(sci_msg_out),
        .intr_msg_in(intr_msg_out), .sci_cnt_out(sci_cnt),
        .intr_cnt_out(intr_cnt));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Reads note their expected data; w=0 means read
    task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
        @(negedge mclk_in);
        if (!w) rd_q.push_back(d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = w;
        reg_rd_in = !w;
        @(negedge mclk_in);
        reg_wr_in = 0;
        reg_rd_in = 0;
    endtask
    task automatic note(logic [5:0] s, logic [5:0] i);
        if (s) sci_q.push_back(s);
        if (i) intr_q.push_back(i);
        sci_n += (s != 0);
        intr_n += (i != 0);
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(negedge mclk_in)
    begin
        if (reg_rvalid_out !== 1'b0)
        begin
            exp_v = rd_q.size() ? rd_q.pop_front() : 'x;
            cmp("rdata", exp_v, reg_rdata_out);
        end
        if (sci_msg_out !== 1'b0)
        begin
            exp_v = sci_q.size() ? sci_q.pop_front() : 'x;
            cmp("sci", exp_v, sci_event_out);
        end
        if (intr_msg_out !== 1'b0)
        begin
            exp_v = intr_q.size() ? intr_q.pop_front() : 'x;
            cmp("intr", exp_v, intr_event_out);
        end
    end
    // Run needs under 600 cycles; the limit leaves a wide margin
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        idle(5);
        rst_in = 0;
        bus(0, `TEM_EXT_CTRL_OFF, 8'h00);
        bus(0, 16'h10E8, 8'h00);
        repeat (10)
        begin
            r = xs();
            sci_thermal_enable_in = r[24];
            int_throttle_enable_in = r[25];
            bus(1, `TEM_SCI_SELECT_OFF, r[7:0]);
            bus(1, `TEM_INTR_SELECT_OFF, r[15:8]);
            bus(0, `TEM_SCI_SELECT_OFF, {2'b00, r[5:0]});
            bus(0, `TEM_INTR_SELECT_OFF, {2'b00, r[13:8]});
            ev = r[21:16] | r[31:26];
            note(r[24] ? ev & r[5:0] : 6'h00, ev & r[13:8]);
            int_trip_set1_in = r[21:16];
            int_trip_set2_in = r[31:26];
            idle(6);
            cmp("set1", r[21:16], trip_set1_out);
            cmp("set2", r[31:26], trip_set2_out);
            cmp("treq", r[25] && ev != 0, throttle_req_out);
            int_trip_set1_in = 0;
            int_trip_set2_in = 0;
            idle(4);
        end
        for (int k = 0; k < 2; k++)
        begin
            rst_in = 1;
            idle(5);
            rst_in = 0;
            sci_thermal_enable_in = 1;
            bus(1, `TEM_SCI_SELECT_OFF, 8'h3F);
            bus(1, `TEM_INTR_SELECT_OFF, 8'h3F);
            first_external_trip_n_in = 0;
            idle(6);
            cmp("thr0", 0, {dram_throttle_out, ctrl_throttle_out});
            cmp("off1", 0, trip_set1_out | trip_set2_out);
            bus(0, `TEM_EXT_CTRL_OFF, 8'h08);
            first_external_trip_n_in = 1;
            idle(4);
            bus(1, `TEM_EXT_CTRL_OFF, cfg[k]);
            bus(1, `TEM_EXT_CTRL_OFF, ~cfg[k] & 8'h7F);
            bus(0, `TEM_EXT_CTRL_OFF, cfg[k]);
            note(ev0[k], ev0[k]);
            first_external_trip_n_in = 0;
            idle(6);
            cmp("set", ev0[k], k ? trip_set1_out : trip_set2_out);
            cmp("unset", 0, k ? trip_set2_out : trip_set1_out);
            cmp("dram", k == 0, dram_throttle_out);
            cmp("ctrl", k == 1, ctrl_throttle_out);
            cmp("treq", 1, throttle_req_out);
            note(ev1[k], ev1[k]);
            second_external_trip_n_in = 0;
            idle(6);
            bus(0, `TEM_EXT_CTRL_OFF, cfg[k] | 8'h0C);
            first_external_trip_n_in = 1;
            second_external_trip_n_in = 1;
            idle(6);
        end
        cmp("hub_sci", sci_n, sci_cnt);
        cmp("hub_intr", intr_n, intr_cnt);
        cmp("left", 0, rd_q.size() + sci_q.size() + intr_q.size());
        complete_run();
    end
endmodule // tem_top_tb_top
